/* hw/gpio_pin_cell.sv */
// Output driver control for one port pin.
// Assumes the pad combines low driver, high driver and weak pull-up.
`timescale 1ns/1ps
module gpio_pin_cell (
  input wire logic out_value,
  input wire logic push_pull,
  input wire logic pullup_disable,
  input wire logic latch_bit,
  output logic pin_out,
  output logic pin_oe,
  output logic pullup_on
);
  // ----------------------------------------
  // Driver select
  // ----------------------------------------
  always_comb begin
    pin_out = out_value;
    // Open drain only pulls low; push-pull drives both levels
    pin_oe = push_pull | ~out_value;
    // Pull-up off when the latch bit is low or push-pull to save power
    pullup_on = ~pullup_disable & ~push_pull & latch_bit;
  end
endmodule : gpio_pin_cell

/* hw/gpio_port_io.sv */
// Port 0, 2 and 3 latches, readback and pin drivers.
// Assumes a core on the SFR bus that marks read-modify-write reads and
// bit accesses; pins are synchronous to ref_clk.
`timescale 1ns/1ps
module gpio_port_io (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_bit,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic sfr_rmw,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [7:0] port0_in,
  output logic [7:0] port0_out,
  output logic [7:0] port0_oe,
  output logic [7:0] port0_pullup,
  input wire logic [5:0] port2_in,
  output logic [5:0] port2_out,
  output logic [5:0] port2_oe,
  output logic [5:0] port2_pullup,
  input wire logic port3_in,
  output logic port3_out,
  output logic port3_oe,
  output logic port3_pullup,
  input wire logic [7:0] port0_push_pull,
  input wire logic [5:0] port2_push_pull
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] port0_latch, next_port0_latch;
  logic [7:0] port2_latch, next_port2_latch;
  logic [7:0] port3_latch, next_port3_latch;
  logic [7:0] port3_drive_mode, next_port3_drive_mode;
  logic [7:0] port_global_control, next_port_global_control;
  logic [7:0] rdata, next_rdata;
  logic [7:0] pin_level;
  logic clock_level;
  logic hit_p0, hit_p2, hit_p3, hit_mode, hit_ctrl;
  logic input_en;

  // Merge a byte or single-bit write into the old latch value
  function automatic logic [7:0] merge_write(
    input logic [7:0] old,
    input logic [7:0] mask,
    input logic bit_op,
    input logic [2:0] sel,
    input logic [7:0] wd
  );
    logic [7:0] res;
    res = old;
    if (bit_op) begin
      // Other bits come from the latch, never the pins
      res[sel] = wd[0];
    end else begin
      res = wd;
    end
    merge_write = (res & mask) | (old & ~mask);
  endfunction : merge_write

  assign input_en = port_global_control[gpio_port_pkg::POS_INPUT_ENABLE];
  assign hit_p0 = sfr_addr == gpio_port_pkg::ADDR_PORT0;
  assign hit_p2 = sfr_addr == gpio_port_pkg::ADDR_PORT2;
  assign hit_p3 = sfr_addr == gpio_port_pkg::ADDR_PORT3;
  assign hit_mode = sfr_addr == gpio_port_pkg::ADDR_PORT3_MODE;
  assign hit_ctrl = sfr_addr == gpio_port_pkg::ADDR_GLOBAL_CTRL;

  // ----------------------------------------
  // Next-state and read mux
  // ----------------------------------------
  always_comb begin
    next_port0_latch = port0_latch;
    next_port2_latch = port2_latch;
    next_port3_latch = port3_latch;
    next_port3_drive_mode = port3_drive_mode;
    next_port_global_control = port_global_control;
    next_rdata = rdata;
    // Pins are not sensed while global inputs are off
    pin_level = '0;
    if (sfr_wr) begin
      if (hit_p0) begin
        next_port0_latch = merge_write(port0_latch,
          gpio_port_pkg::MASK_PORT0, sfr_bit, sfr_bit_sel,
          sfr_wdata);
      end
      if (hit_p2) begin
        next_port2_latch = merge_write(port2_latch,
          gpio_port_pkg::MASK_PORT2, sfr_bit, sfr_bit_sel,
          sfr_wdata);
      end
      if (hit_p3) begin
        next_port3_latch = merge_write(port3_latch,
          gpio_port_pkg::MASK_PORT3, sfr_bit, sfr_bit_sel,
          sfr_wdata);
      end
      if (hit_mode) begin
        next_port3_drive_mode = merge_write(port3_drive_mode,
          gpio_port_pkg::MASK_PORT3_MODE, sfr_bit, sfr_bit_sel,
          sfr_wdata);
      end
      if (hit_ctrl) begin
        next_port_global_control = merge_write(port_global_control,
          gpio_port_pkg::MASK_GLOBAL_CTRL, sfr_bit, sfr_bit_sel,
          sfr_wdata);
      end
    end
    if (sfr_rd) begin
      if (hit_p0) begin
        pin_level = input_en ? port0_in : 8'h00;
        next_rdata = sfr_rmw ? port0_latch : pin_level;
      end else if (hit_p2) begin
        pin_level = input_en ? {2'b00, port2_in} : 8'h00;
        next_rdata = (sfr_rmw ? port2_latch : pin_level)
          & gpio_port_pkg::MASK_PORT2;
      end else if (hit_p3) begin
        pin_level = input_en ? {7'h00, port3_in} : 8'h00;
        next_rdata = (sfr_rmw ? port3_latch : pin_level)
          & gpio_port_pkg::MASK_PORT3;
      end else if (hit_mode) begin
        next_rdata = port3_drive_mode;
      end else if (hit_ctrl) begin
        next_rdata = port_global_control;
      end else begin
        // Unmapped addresses read as zero
        next_rdata = 8'h00;
      end
      if (sfr_bit) begin
        next_rdata = {7'h00, next_rdata[sfr_bit_sel]};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port0_latch <= gpio_port_pkg::RST_PORT0;
      port2_latch <= gpio_port_pkg::RST_PORT2 & gpio_port_pkg::MASK_PORT2;
      port3_latch <= gpio_port_pkg::RST_PORT3 & gpio_port_pkg::MASK_PORT3;
      port3_drive_mode <= gpio_port_pkg::RST_PORT3_MODE;
      port_global_control <= gpio_port_pkg::RST_GLOBAL_CTRL;
      rdata <= 8'h00;
    end else if (clk_en) begin
      port0_latch <= next_port0_latch;
      port2_latch <= next_port2_latch;
      port3_latch <= next_port3_latch;
      port3_drive_mode <= next_port3_drive_mode;
      port_global_control <= next_port_global_control;
      rdata <= next_rdata;
    end
  end

  assign sfr_rdata = rdata;

  // ----------------------------------------
  // Inverted system clock on port 0 pin 0
  // ----------------------------------------
  // Clock selected by the global control clock-out bit; glitch-free switching is not
  // attempted, so change the route while the pin is unused.
  assign clock_level = ~ref_clk;

  // ----------------------------------------
  // Pin cells
  // ----------------------------------------
  for (genvar i = 0; i < gpio_port_pkg::PORT_WIDTH; i++) begin : g_p0
    logic val;
    if (i == gpio_port_pkg::POS_CLOCK_PIN) begin : g_clk
      assign val = port_global_control[gpio_port_pkg::POS_CLOCK_OUT]
        ? clock_level : port0_latch[i];
    end else begin : g_lat
      assign val = port0_latch[i];
    end
    gpio_pin_cell u_cell (
      .out_value(val),
      .push_pull(port0_push_pull[i]),
      .pullup_disable(port_global_control[gpio_port_pkg::POS_PULLUP_DISABLE]),
      .latch_bit(port0_latch[i]),
      .pin_out(port0_out[i]),
      .pin_oe(port0_oe[i]),
      .pullup_on(port0_pullup[i])
    );
  end

  for (genvar j = 0; j < 6; j++) begin : g_p2
    gpio_pin_cell u_cell (
      .out_value(port2_latch[j]),
      .push_pull(port2_push_pull[j]),
      .pullup_disable(port_global_control[gpio_port_pkg::POS_PULLUP_DISABLE]),
      .latch_bit(port2_latch[j]),
      .pin_out(port2_out[j]),
      .pin_oe(port2_oe[j]),
      .pullup_on(port2_pullup[j])
    );
  end

  gpio_pin_cell u_p3 (
    .out_value(port3_latch[0]),
    .push_pull(port3_drive_mode[gpio_port_pkg::POS_P3_PUSH_PULL]),
    .pullup_disable(port_global_control[gpio_port_pkg::POS_PULLUP_DISABLE]),
    .latch_bit(port3_latch[0]),
    .pin_out(port3_out),
    .pin_oe(port3_oe),
    .pullup_on(port3_pullup)
  );
endmodule : gpio_port_io

/* hw/gpio_port_pkg.sv */
// Constants used by the port block for register decode, reset, masking and pin cell wiring.
// Assumes an 8-bit special-function-register bus with bit addressing.
package gpio_port_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_PORT0 = 8'h80;
  localparam logic [7:0] ADDR_PORT2 = 8'hA0;
  localparam logic [7:0] ADDR_PORT3_MODE = 8'hA7;
  localparam logic [7:0] ADDR_PORT3 = 8'hB0;
  localparam logic [7:0] ADDR_GLOBAL_CTRL = 8'hE2;
  // ----------------------------------------
  // Reset values and implemented bits
  // ----------------------------------------
  localparam logic [7:0] RST_PORT0 = 8'hFF;
  localparam logic [7:0] RST_PORT2 = 8'hFF;
  localparam logic [7:0] RST_PORT3 = 8'hFF;
  localparam logic [7:0] RST_PORT3_MODE = 8'h00;
  localparam logic [7:0] RST_GLOBAL_CTRL = 8'h40;
  localparam logic [7:0] MASK_PORT0 = 8'hFF;
  localparam logic [7:0] MASK_PORT2 = 8'h3F;
  localparam logic [7:0] MASK_PORT3 = 8'h01;
  localparam logic [7:0] MASK_PORT3_MODE = 8'h01;
  localparam logic [7:0] MASK_GLOBAL_CTRL = 8'hC1;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POS_PULLUP_DISABLE = 7;
  localparam int POS_INPUT_ENABLE = 6;
  localparam int POS_CLOCK_OUT = 0;
  localparam int POS_P3_PUSH_PULL = 0;
  localparam int POS_CLOCK_PIN = 0;
  localparam int PORT_WIDTH = 8;
  localparam int BIT_SEL_WIDTH = 3;
endpackage : gpio_port_pkg

/* sim/gpio_port_io_assertions.sv */
// Checker for the port block: latch, readback and pin drive.
// Bound onto gpio_port_io; one clock domain.
`timescale 1ns/1ps
module gpio_port_io_assertions (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_bit,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic sfr_rmw,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic [7:0] port0_in,
  input wire logic [7:0] port0_out,
  input wire logic [7:0] port0_oe,
  input wire logic [5:0] port2_out,
  input wire logic [5:0] port2_pullup,
  input wire logic port3_out,
  input wire logic port3_oe,
  input wire logic port3_pullup,
  input wire logic [7:0] port0_push_pull,
  input wire logic [5:0] port2_push_pull
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire wr = clk_en & sfr_wr & !sfr_bit;
  wire bw = clk_en & sfr_wr & sfr_bit;
  wire rd = clk_en & sfr_rd & !sfr_wr & !sfr_bit;
  // Pin 0 of port 0 may carry the clock, so it is left out here
  property p_wr0; wr && sfr_addr == 8'h80 |=>
    port0_out[7:1] == $past(sfr_wdata[7:1]); endproperty
  a_wr0: assert property (p_wr0) else $error("port0 write");
  property p_wr2; wr && sfr_addr == 8'hA0 |=>
    port2_out == $past(sfr_wdata[5:0]); endproperty
  a_wr2: assert property (p_wr2) else $error("port2 write");
  property p_bit; bw && sfr_addr == 8'hA0 && sfr_bit_sel < 3'h6 |=>
    port2_out == (($past(port2_out) & ~(6'h01 << $past(sfr_bit_sel)))
    | (6'($past(sfr_wdata[0])) << $past(sfr_bit_sel))); endproperty
  a_bit: assert property (p_bit) else $error("bit write");
  property p_hold; !clk_en |=> $stable(port2_out) && $stable(sfr_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("frozen state");
  property p_oe; port0_oe[7:1] == (port0_push_pull[7:1] | ~port0_out[7:1]);
  endproperty
  a_oe: assert property (p_oe) else $error("port0 enable");
  property p_pu; (port2_pullup & (port2_push_pull | ~port2_out)) == 6'h00;
  endproperty
  a_pu: assert property (p_pu) else $error("port2 pullup");
  property p_p3; port3_pullup |-> port3_out && !port3_oe; endproperty
  a_p3: assert property (p_p3) else $error("port3 pullup");
  property p_rd; rd && !sfr_rmw && sfr_addr == 8'h80 |=>
    (sfr_rdata & ~$past(port0_in)) == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("pin read");
  property p_rmw; rd && sfr_rmw && sfr_addr == 8'h80 |=>
    sfr_rdata[7:1] == $past(port0_out[7:1]); endproperty
  a_rmw: assert property (p_rmw) else $error("latch read");
  property p_p3rd; clk_en && sfr_rd && sfr_addr == 8'hB0 |=>
    sfr_rdata[7:1] == 7'h00; endproperty
  a_p3rd: assert property (p_p3rd) else $error("port3 read");
  c_rmw: cover property (rd && sfr_rmw);
  c_bit: cover property (bw);
  c_pp: cover property (port3_oe);
endmodule : gpio_port_io_assertions
bind gpio_port_io gpio_port_io_assertions chk_i (.*);

/* sim/gpio_port_io_tb.sv */
// Self-checking bench for the port block with a pin model.
// Random pin drive and modes from a fixed seed.
`timescale 1ns/1ps
module gpio_port_io_tb;
  logic ref_clk = 0, resetn = 0, clk_en = 1, sfr_wr = 0, sfr_rd = 0;
  logic sfr_bit = 0, sfr_rmw = 0, port3_out, port3_oe, port3_pullup;
  logic [2:0] sfr_bit_sel = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, port0_out, port0_oe;
  logic [7:0] port0_pullup, port0_push_pull = 0;
  logic [5:0] port2_out, port2_oe, port2_pullup, port2_push_pull = 0;
  logic [14:0] ext_val = 0, ext_en = 0, level;
  wire [7:0] port0_in = level[7:0];
  wire [5:0] port2_in = level[13:8];
  wire port3_in = level[14];
  int bad_count = 0, total_checks = 0, seed = 42413;
  logic [7:0] ad[3] = '{8'h80, 8'hA0, 8'hB0};
  logic [7:0] mk[3] = '{8'hFF, 8'h3F, 8'h01};
  int sh[3] = '{0, 8, 14};
  gpio_port_io gpio_port_io_i (.*);
  pin_world pin_world_i (.ref_clk(ref_clk), .ext_en(ext_en),
    .pin_out({port3_out, port2_out, port0_out}), .ext_val(ext_val),
    .pin_oe({port3_oe, port2_oe, port0_oe}), .level(level),
    .pin_pu({port3_pullup, port2_pullup, port0_pullup}));
  always #4 ref_clk = ~ref_clk;
  task automatic chk(input string n, input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic acc(input logic [7:0] a, d = 0, input logic w = 0,
      b = 0, m = 0, input logic [2:0] s = 0);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= w;
    sfr_rd <= !w;
    sfr_bit <= b;
    sfr_rmw <= m;
    sfr_bit_sel <= s;
    @(posedge ref_clk);
    sfr_wr <= 0;
    sfr_rd <= 0;
    #1;
  endtask : acc
  // Push-pull pins read the latch; released ones the far side or pull-up
  function automatic logic [7:0] xpin(int k, logic [7:0] d);
    logic [14:0] p;
    p = {1'b0, port2_push_pull, port0_push_pull} | ~ext_en | ext_val;
    return d & mk[k] & 8'(p >> sh[k]);
  endfunction : xpin
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] d, e, o;
    logic [2:0] s;
    int k;
    repeat (5) @(posedge ref_clk);
    resetn <= 1;
    acc(8'hE2);
    chk("ctrl", sfr_rdata, 8'h40);
    acc(8'h80, 0, 0, 0, 1);
    chk("p0 reset", sfr_rdata, 8'hFF);
    acc(8'hA7);
    chk("mode", sfr_rdata, 8'h00);
    chk("p3 pin", {6'h0, port3_oe, port3_pullup}, 8'h01);
    acc(8'h3C);
    chk("unmapped", sfr_rdata, 8'h00);
    for (int i = 0; i < 60; i++) begin
      k = i % 3;
      d = 8'($random(seed));
      s = (k == 2) ? 3'h0 : 3'($random(seed) & 3);
      @(posedge ref_clk);
      port0_push_pull <= 8'($random(seed));
      port2_push_pull <= 6'($random(seed));
      ext_val <= 15'($random(seed));
      ext_en <= 15'($random(seed));
      acc(ad[k], d, 1);
      acc(ad[k], 0, 0, 0, 1);
      chk("rmw", sfr_rdata, d & mk[k]);
      // Drive enable: push-pull always drives, open drain only on a zero
      e = (k == 0) ? port0_push_pull : (k == 1) ? 8'(port2_push_pull) : 8'h00;
      o = (k == 0) ? port0_oe : (k == 1) ? 8'(port2_oe) : 8'(port3_oe);
      chk("oe", o, (e | ~d) & mk[k]);
      acc(ad[k]);
      chk("pins", sfr_rdata, xpin(k, d));
      d[s] = ~d[s];
      acc(ad[k], {7'h0, d[s]}, 1, 1, 0, s);
      acc(ad[k], 0, 0, 0, 1);
      chk("bit wr", sfr_rdata, d & mk[k]);
      acc(ad[k], 0, 0, 1, 1, s);
      chk("bit rd", sfr_rdata, {7'h0, d[s]});
    end
    acc(8'hE2, 8'h00, 1);
    acc(8'h80);
    chk("no input", sfr_rdata, 8'h00);
    acc(8'hE2, 8'hFF, 1);
    acc(8'hE2);
    chk("ctrl", sfr_rdata, 8'hC1);
    chk("pullup", port0_pullup, 8'h00);
    repeat (2) begin
      chk("clk out", {7'h0, port0_out[0]}, {7'h0, ~ref_clk});
      #4;
    end
    acc(8'hA7, 8'hFF, 1);
    acc(8'hA7);
    chk("mode", sfr_rdata, 8'h01);
    acc(8'hB0, 8'h00, 1);
    chk("p3 drive", {6'h0, port3_oe, port3_out}, 8'h02);
    @(posedge ref_clk);
    resetn <= 0;
    @(posedge ref_clk);
    resetn <= 1;
    acc(8'hE2);
    chk("ctrl", sfr_rdata, 8'h40);
    @(posedge ref_clk);
    clk_en <= 0;
    acc(8'hA0, 8'h00, 1);
    @(posedge ref_clk);
    clk_en <= 1;
    acc(8'hA0, 0, 0, 0, 1);
    chk("frozen", sfr_rdata, 8'h3F);
    tally_and_finish();
  end
endmodule : gpio_port_io_tb

/* sim/pin_world.sv */
// External circuitry on all fifteen port pins.
// Bench picks which released pins it drives and to what level.
`timescale 1ns/1ps
module pin_world (
  input wire logic ref_clk,
  input wire logic [14:0] pin_out,
  input wire logic [14:0] pin_oe,
  input wire logic [14:0] pin_pu,
  input wire logic [14:0] ext_en,
  input wire logic [14:0] ext_val,
  output logic [14:0] level
);
  logic [14:0] last = 15'h0000;
  always @(posedge ref_clk) last <= level;
  // A floating pin shows the inverse of its last level, never a held one
  always_comb level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pu | ~last));
endmodule : pin_world
